// file: core/memory_map_page_arbiter.sv
/*
  Memory map, page expansion, illegal access detection and master
  arbitration for a CPU and a background debug master.
  Assumes both masters and the register port run on clk; masters hold a
  request until granted; the debug master never issues misaligned words.
*/
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module memory_map_page_arbiter #(
  parameter int RAM_SIZE = 2048,
  parameter int FLASH_SIZE = 32768,
  parameter int STARVE_CYCLES = mmap_pkg::STARVE_LIMIT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Mode and debug state.
  input wire logic single_chip,
  input wire logic debug_active,
  input wire logic debug_page_en,
  input wire logic debug_hw_cmd,
  input wire logic cpu_firmware,
  input wire logic debug_read_cycle,
  input wire logic debug_write_cycle,
  // CPU master.
  input wire mmap_pkg::master_req_s cpu_req,
  input wire logic cpu_op_done,
  output logic cpu_grant,
  output logic cpu_stall,
  output logic [15:0] cpu_rdata,
  // Debug master.
  input wire mmap_pkg::master_req_s dbg_req,
  output logic dbg_grant,
  output logic [15:0] dbg_rdata,
  // Far call and return from the CPU core.
  input wire logic call_start,
  input wire logic call_indirect,
  input wire logic [7:0] call_imm_page,
  input wire logic [7:0] call_mem_page,
  input wire logic rtc_start,
  input wire logic [7:0] stack_pull_data,
  output logic push_ret,
  output logic push_page,
  output logic [7:0] push_data,
  output logic pull_page,
  output logic pull_ret,
  output logic refill,
  output logic cpu_no_irq,
  // Target bus.
  output mmap_pkg::target_req_s tgt_req,
  output mmap_pkg::target_e tgt_sel,
  input wire logic [15:0] tgt_rdata,
  // Illegal access reset request.
  output logic illegal_reset
);

  localparam logic [18:0] RAM_HI_P1 = 19'(mmap_pkg::GLB_RAM_LO) + 19'(RAM_SIZE);
  localparam logic [18:0] FLASH_LO = mmap_pkg::GLB_TOP_PLUS1 - 19'(FLASH_SIZE);

  logic [7:0] page_reg;
  logic [3:0] dbg_page_reg;
  logic info_vis_reg;
  logic [7:0] starve_reg;
  logic starved_reg;
  logic seq_page_we;
  logic [7:0] seq_page_wdata;
  logic seq_busy;
  logic cpu_win;
  logic dbg_win;
  logic cpu_go;
  logic dbg_go;
  logic [17:0] cpu_gaddr;
  logic [17:0] dbg_gaddr;
  mmap_pkg::target_e cpu_tgt;
  mmap_pkg::target_e dbg_tgt;
  logic cpu_rd_pend_reg;
  logic dbg_rd_pend_reg;
  logic [7:0] reg_rdata_reg;
  logic reg_hit_reg;

  // Expand a local address to a global one with the given window page.
  function automatic logic [17:0] expand(input logic [15:0] la, input logic [7:0] pg);
    logic [7:0] p;
    p = page_sel(la, pg);
    // Registers, holes and RAM keep their own global address, else nothing could reach them.
    if (19'(la) < RAM_HI_P1) begin
      return {2'b00, la};
    end
    return {p[3:0], la[13:0]};
  endfunction

  function automatic logic [7:0] page_sel(input logic [15:0] la, input logic [7:0] pg);
    logic [7:0] r;
    r = mmap_pkg::PAGE_FIX;
    if (la < 16'h4000) begin
      r = mmap_pkg::PAGE_BLK0;
    end else if (la < mmap_pkg::LOC_WIN_LO) begin
      r = mmap_pkg::PAGE_BLK1;
    end else if (la <= mmap_pkg::LOC_WIN_HI) begin
      r = pg;
    end
    // Local 0xC000 and above always uses the fixed page.
    return r;
  endfunction

  // Is this local address a debug resource in active debug mode.
  function automatic logic debug_hit(input logic [15:0] la, input logic [7:0] pg);
    logic h;
    h = la >= mmap_pkg::LOC_DBG_LO;
    if (la >= mmap_pkg::LOC_DBG_WIN_LO && la <= mmap_pkg::LOC_WIN_HI &&
        pg == mmap_pkg::PAGE_DBG_ALIAS) begin
      h = 1'b1;
    end
    return h;
  endfunction

  // Decode a global address to a target.
  function automatic mmap_pkg::target_e decode(input logic [17:0] ga, input logic vis);
    mmap_pkg::target_e t;
    t = mmap_pkg::TGT_NONE;
    if (ga <= mmap_pkg::GLB_REG_HI) begin
      t = mmap_pkg::TGT_REG;
    end else if (ga <= mmap_pkg::GLB_INFO_HI) begin
      t = vis ? mmap_pkg::TGT_INFO : mmap_pkg::TGT_NONE;
    end else if (ga <= mmap_pkg::GLB_HOLE_HI) begin
      t = mmap_pkg::TGT_NONE;
    end else if (19'(ga) < RAM_HI_P1) begin
      t = mmap_pkg::TGT_RAM;
    end else if (19'(ga) >= FLASH_LO) begin
      t = mmap_pkg::TGT_FLASH;
    end
    return t;
  endfunction

  page_sequencer u_seq (
    .clk(clk),
    .resetn(resetn),
    .call_start(call_start),
    .call_indirect(call_indirect),
    .call_imm_page(call_imm_page),
    .call_mem_page(call_mem_page),
    .rtc_start(rtc_start),
    .stack_pull_data(stack_pull_data),
    .cur_page(page_reg),
    .page_we(seq_page_we),
    .page_wdata(seq_page_wdata),
    .push_ret(push_ret),
    .push_page(push_page),
    .push_data(push_data),
    .pull_page(pull_page),
    .pull_ret(pull_ret),
    .refill(refill),
    .busy(seq_busy)
  );

  // Address expansion. The debug page applies to debug work only.
  always_comb begin
    cpu_gaddr = expand(cpu_req.addr, page_reg);
    dbg_gaddr = expand(dbg_req.addr, page_reg);
    if (debug_page_en && (cpu_firmware || debug_hw_cmd) &&
        dbg_req.addr >= mmap_pkg::LOC_WIN_LO && dbg_req.addr <= mmap_pkg::LOC_WIN_HI) begin
      dbg_gaddr = {dbg_page_reg, dbg_req.addr[13:0]};
    end
    if (debug_page_en && cpu_firmware &&
        cpu_req.addr >= mmap_pkg::LOC_WIN_LO && cpu_req.addr <= mmap_pkg::LOC_WIN_HI) begin
      cpu_gaddr = {dbg_page_reg, cpu_req.addr[13:0]};
    end
  end

  // Target selection; debug resources only in debug cycles, hiding others.
  always_comb begin
    cpu_tgt = decode(cpu_gaddr, info_vis_reg);
    dbg_tgt = decode(dbg_gaddr, info_vis_reg);
    if (debug_active && (debug_read_cycle || debug_write_cycle) &&
        debug_hit(cpu_req.addr, page_reg)) begin
      cpu_tgt = mmap_pkg::TGT_DEBUG;
    end
    if (debug_active && (debug_read_cycle || debug_write_cycle) &&
        debug_hit(dbg_req.addr, page_reg)) begin
      dbg_tgt = mmap_pkg::TGT_DEBUG;
    end
  end

  // Arbitration: CPU first unless the debug master has starved.
  always_comb begin
    cpu_win = cpu_req.req && !(starved_reg && dbg_req.req);
    dbg_win = dbg_req.req && !cpu_win;
    cpu_go = cpu_win;
    dbg_go = dbg_win;
  end

  // Starvation counter for the debug master.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      starve_reg <= 8'h00;
    end else if (!dbg_req.req || dbg_go) begin
      starve_reg <= 8'h00;
    end else if (32'(starve_reg) < STARVE_CYCLES) begin
      starve_reg <= starve_reg + 8'h01;
    end
  end

  // Takeover waits for the CPU's current operation to end.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      starved_reg <= 1'b0;
    end else if (!dbg_req.req || dbg_go) begin
      starved_reg <= starved_reg && dbg_req.req && !dbg_go;
    end else if (32'(starve_reg) >= STARVE_CYCLES && cpu_op_done) begin
      starved_reg <= 1'b1;
    end
  end

  // Target bus drive, one master at a time.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tgt_req <= '0;
      tgt_sel <= mmap_pkg::TGT_NONE;
      cpu_grant <= 1'b0;
      dbg_grant <= 1'b0;
      cpu_stall <= 1'b0;
    end else begin
      cpu_grant <= cpu_go;
      dbg_grant <= dbg_go;
      cpu_stall <= cpu_req.req && !cpu_go;
      tgt_req <= '0;
      tgt_sel <= mmap_pkg::TGT_NONE;
      if (cpu_go) begin
        tgt_req <= {1'b1, cpu_req.wr, cpu_req.word, cpu_gaddr, cpu_req.wdata, 1'b0};
        tgt_sel <= cpu_tgt;
      end else if (dbg_go) begin
        // Misaligned debug words never arrive, so no split is done here.
        tgt_req <= {1'b1, dbg_req.wr, dbg_req.word, dbg_gaddr, dbg_req.wdata, 1'b1};
        tgt_sel <= dbg_tgt;
      end
    end
  end

  // Illegal access reset, a single pulse per offending CPU access.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      illegal_reset <= 1'b0;
    end else begin
      illegal_reset <= cpu_go && single_chip && !cpu_firmware &&
                       cpu_tgt == mmap_pkg::TGT_NONE;
    end
  end

  // Page registers: bus writes and sequencer writes. Sequencer wins.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      page_reg <= mmap_pkg::PAGE_RESET;
    end else if (seq_page_we) begin
      page_reg <= seq_page_wdata;
    end else if (cpu_go ? (cpu_req.wr && cpu_gaddr == mmap_pkg::ADDR_PAGE_IDX) :
                 (dbg_go && dbg_req.wr && dbg_gaddr == mmap_pkg::ADDR_PAGE_IDX)) begin
      page_reg <= cpu_go ? cpu_req.wdata[7:0] : dbg_req.wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dbg_page_reg <= mmap_pkg::DBG_PAGE_RESET;
      info_vis_reg <= 1'b0;
    end else begin
      if (dbg_go && dbg_req.wr && dbg_gaddr == mmap_pkg::ADDR_DBG_PAGE) begin
        dbg_page_reg <= dbg_req.wdata[3:0];
      end
      if (cpu_go && cpu_req.wr && cpu_gaddr == mmap_pkg::ADDR_MAP_CTL) begin
        info_vis_reg <= cpu_req.wdata[mmap_pkg::INFO_VIS_BIT];
      end else if (dbg_go && dbg_req.wr && dbg_gaddr == mmap_pkg::ADDR_MAP_CTL) begin
        info_vis_reg <= dbg_req.wdata[mmap_pkg::INFO_VIS_BIT];
      end
    end
  end

  // Local register reads are captured with the request.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata_reg <= 8'h00;
      reg_hit_reg <= 1'b0;
      cpu_rd_pend_reg <= 1'b0;
      dbg_rd_pend_reg <= 1'b0;
    end else begin
      cpu_rd_pend_reg <= cpu_go && !cpu_req.wr;
      dbg_rd_pend_reg <= dbg_go && !dbg_req.wr;
      reg_hit_reg <= 1'b0;
      reg_rdata_reg <= 8'h00;
      if (tgt_sel_local(cpu_go ? cpu_gaddr : dbg_gaddr) && (cpu_go || dbg_go)) begin
        reg_hit_reg <= 1'b1;
        reg_rdata_reg <= read_local(cpu_go ? cpu_gaddr : dbg_gaddr);
      end
    end
  end

  function automatic logic tgt_sel_local(input logic [17:0] ga);
    return ga == mmap_pkg::ADDR_PAGE_IDX || ga == mmap_pkg::ADDR_MAP_CTL ||
           ga == mmap_pkg::ADDR_DBG_PAGE;
  endfunction

  function automatic logic [7:0] read_local(input logic [17:0] ga);
    logic [7:0] d;
    d = 8'h00;
    if (ga == mmap_pkg::ADDR_PAGE_IDX) begin
      d = page_reg;
    end else if (ga == mmap_pkg::ADDR_MAP_CTL) begin
      d = {7'h00, info_vis_reg};
    end else if (ga == mmap_pkg::ADDR_DBG_PAGE) begin
      d = {4'h0, dbg_page_reg};
    end
    return d;
  endfunction

  // Read data return. CPU bytes arrive high-first and are swapped here;
  // the debug master takes the bus order unchanged.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cpu_rdata <= 16'h0000;
      dbg_rdata <= 16'h0000;
    end else begin
      if (cpu_rd_pend_reg) begin
        cpu_rdata <= reg_hit_reg ? {8'h00, reg_rdata_reg} :
                     {tgt_rdata[7:0], tgt_rdata[15:8]};
      end
      if (dbg_rd_pend_reg) begin
        dbg_rdata <= reg_hit_reg ? {8'h00, reg_rdata_reg} : tgt_rdata;
      end
    end
  end

  // Interrupts stay off for the whole far call or return run.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cpu_no_irq <= 1'b0;
    end else begin
      cpu_no_irq <= seq_busy || call_start || rtc_start;
    end
  end

  // No interrupt output exists on this block.

endmodule // memory_map_page_arbiter

// file: core/mmap_pkg.sv
/*
  Package for the memory map and page arbiter: local and global map
  constants, page defaults, arbitration counts and master bus structs.
  Assumes a single 25 MHz system clock shared by all users.
*/
package mmap_pkg;

  // Local map boundaries.
  localparam logic [15:0] LOC_WIN_LO = 16'h8000;
  localparam logic [15:0] LOC_WIN_HI = 16'hbfff;
  localparam logic [15:0] LOC_FIX_LO = 16'hc000;
  localparam logic [15:0] LOC_DBG_LO = 16'hff00;
  localparam logic [15:0] LOC_DBG_WIN_LO = 16'hbf00;

  // Fixed pages for the unpaged 16 kbyte blocks, then the reset pages and the debug alias page.
  localparam logic [7:0] PAGE_BLK0 = 8'hfc;
  localparam logic [7:0] PAGE_BLK1 = 8'hfd;
  localparam logic [7:0] PAGE_FIX = 8'hff;
  localparam logic [7:0] PAGE_RESET = 8'hfe;
  localparam logic [7:0] PAGE_DBG_ALIAS = 8'hff;
  localparam logic [3:0] DBG_PAGE_RESET = 4'hf;

  // Global map.
  localparam logic [17:0] GLB_REG_HI = 18'h003ff;
  localparam logic [17:0] GLB_INFO_LO = 18'h00400;
  localparam logic [17:0] GLB_INFO_HI = 18'h0047f;
  localparam logic [17:0] GLB_HOLE_HI = 18'h007ff;
  localparam logic [17:0] GLB_RAM_LO = 18'h00800;
  localparam logic [17:0] GLB_FLASH_HI = 18'h3ffff;
  localparam logic [18:0] GLB_TOP_PLUS1 = 19'h40000;

  // Page index, map control and debug page register addresses in the register space.
  localparam logic [17:0] ADDR_PAGE_IDX = 18'h00030;
  localparam logic [17:0] ADDR_MAP_CTL = 18'h00033;
  localparam logic [17:0] ADDR_DBG_PAGE = 18'h00034;
  localparam int INFO_VIS_BIT = 0;

  // Debug starvation limit in cycles.
  localparam int STARVE_LIMIT = 128;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_REG,
    TGT_INFO,
    TGT_RAM,
    TGT_FLASH,
    TGT_DEBUG
  } target_e;

  typedef struct packed {
    logic req;
    logic wr;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } master_req_s;

  typedef struct packed {
    logic req;
    logic wr;
    logic word;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic master_dbg;
  } target_req_s;

endpackage

// file: core/page_sequencer.sv
/*
  Far-call and far-return page sequencer. Holds the save and restore
  steps for the program page index during those instructions.
  Assumes the CPU core pulses start strobes and accepts stack strobes
  one per cycle; interrupts are held off by cpu_no_irq during the run.
*/
`timescale 1ns/10ps
module page_sequencer (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Commands from the core.
  input wire logic call_start,
  input wire logic call_indirect,
  input wire logic [7:0] call_imm_page,
  input wire logic [7:0] call_mem_page,
  input wire logic rtc_start,
  input wire logic [7:0] stack_pull_data,
  input wire logic [7:0] cur_page,
  // Results.
  output logic page_we,
  output logic [7:0] page_wdata,
  output logic push_ret,
  output logic push_page,
  output logic [7:0] push_data,
  output logic pull_page,
  output logic pull_ret,
  output logic refill,
  output logic busy
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_C_RET,
    S_C_PAGE,
    S_C_JUMP,
    S_R_RET,
    S_R_WRITE,
    S_R_REFILL
  } seq_e;

  seq_e state_reg;
  logic [7:0] temp_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (call_start) begin
            state_reg <= S_C_RET;
          end else if (rtc_start) begin
            state_reg <= S_R_RET;
          end
        end
        S_C_RET: state_reg <= S_C_PAGE;
        S_C_PAGE: state_reg <= S_C_JUMP;
        S_C_JUMP: state_reg <= S_IDLE;
        S_R_RET: state_reg <= S_R_WRITE;
        S_R_WRITE: state_reg <= S_R_REFILL;
        S_R_REFILL: state_reg <= S_IDLE;
      endcase
    end
  end

  // Temporary page: old page on call, pulled page on return.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      temp_reg <= 8'h00;
    end else if (state_reg == S_IDLE && call_start) begin
      temp_reg <= cur_page;
    end else if (state_reg == S_IDLE && rtc_start) begin
      temp_reg <= stack_pull_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      page_we <= 1'b0;
      page_wdata <= 8'h00;
      push_ret <= 1'b0;
      push_page <= 1'b0;
      push_data <= 8'h00;
      pull_page <= 1'b0;
      pull_ret <= 1'b0;
      refill <= 1'b0;
      busy <= 1'b0;
    end else begin
      page_we <= 1'b0;
      push_ret <= 1'b0;
      push_page <= 1'b0;
      pull_page <= 1'b0;
      pull_ret <= 1'b0;
      refill <= 1'b0;
      if (state_reg == S_IDLE && call_start) begin
        page_we <= 1'b1;
        page_wdata <= call_indirect ? call_mem_page : call_imm_page;
        busy <= 1'b1;
      end else if (state_reg == S_IDLE && rtc_start) begin
        pull_page <= 1'b1;
        busy <= 1'b1;
      end else if (state_reg == S_C_RET) begin
        push_ret <= 1'b1;
      end else if (state_reg == S_C_PAGE) begin
        push_page <= 1'b1;
        push_data <= temp_reg;
      end else if (state_reg == S_C_JUMP) begin
        refill <= 1'b1;
        busy <= 1'b0;
      end else if (state_reg == S_R_RET) begin
        pull_ret <= 1'b1;
      end else if (state_reg == S_R_WRITE) begin
        page_we <= 1'b1;
        page_wdata <= temp_reg;
      end else if (state_reg == S_R_REFILL) begin
        refill <= 1'b1;
        busy <= 1'b0;
      end
    end
  end

endmodule // page_sequencer

// file: test/mmap_props.sv
/*
  Checker for the memory map and page arbiter, bound to its top module.
  Assumes one clock and the synchronous active-low reset of the block.
*/
`timescale 1ns/10ps
module mmap_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Inputs watched.
  input wire logic single_chip,
  input wire logic cpu_firmware,
  input wire logic debug_read_cycle,
  input wire logic debug_write_cycle,
  input wire mmap_pkg::master_req_s cpu_req,
  input wire mmap_pkg::master_req_s dbg_req,
  input wire logic call_start,
  // Outputs watched.
  input wire logic cpu_grant,
  input wire logic dbg_grant,
  input wire logic push_ret,
  input wire logic push_page,
  input wire logic pull_page,
  input wire logic pull_ret,
  input wire logic refill,
  input wire logic cpu_no_irq,
  input wire mmap_pkg::target_req_s tgt_req,
  input wire mmap_pkg::target_e tgt_sel,
  input wire logic illegal_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  one_master_a: assert property (!(cpu_grant && dbg_grant))
    else $error("Both masters granted.");
  dbg_cause_a: assert property (dbg_grant |-> $past(dbg_req.req))
    else $error("Debug grant without request.");
  cpu_first_a: assert property ($rose(dbg_req.req) && cpu_req.req |=> !dbg_grant)
    else $error("Debug won over the CPU.");
  ill_pulse_a: assert property (illegal_reset |=> !illegal_reset)
    else $error("Illegal reset longer than one cycle.");
  ill_cause_a: assert property (illegal_reset |-> $past(single_chip && !cpu_firmware))
    else $error("Illegal reset without cause.");
  dbg_cycle_a: assert property (tgt_req.req && tgt_sel == mmap_pkg::TGT_DEBUG
    |-> $past(debug_read_cycle || debug_write_cycle)) else $error("Debug target outside cycle.");
  fixed_map_a: assert property (tgt_req.req && !tgt_req.master_dbg
    && tgt_sel == mmap_pkg::TGT_FLASH && $past(cpu_req.addr[15:14]) == 2'b11
    |-> tgt_req.addr[17:14] == 4'hf) else $error("Upper block was paged.");
  push_order_a: assert property (push_ret |=> push_page ##1 refill)
    else $error("Far call stacking order wrong.");
  pull_order_a: assert property (pull_page |=> pull_ret ##2 refill)
    else $error("Far return order wrong.");
  call_quiet_a: assert property (call_start |=> cpu_no_irq [*3])
    else $error("Far call not shielded.");
endmodule // mmap_props

bind memory_map_page_arbiter mmap_props i_props (.clk(clk), .resetn(resetn),
  .single_chip(single_chip), .cpu_firmware(cpu_firmware),
  .debug_read_cycle(debug_read_cycle), .debug_write_cycle(debug_write_cycle),
  .cpu_req(cpu_req), .dbg_req(dbg_req), .call_start(call_start), .cpu_grant(cpu_grant),
  .dbg_grant(dbg_grant), .push_ret(push_ret), .push_page(push_page), .pull_page(pull_page),
  .pull_ret(pull_ret), .refill(refill), .cpu_no_irq(cpu_no_irq), .tgt_req(tgt_req),
  .tgt_sel(tgt_sel), .illegal_reset(illegal_reset));

// file: test/target_model.sv
/*
  Memories on the target bus: read data follow the global address.
  Assumes the registered target request and same-cycle read data.
*/
`timescale 1ns/10ps
module target_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Target bus.
  input wire mmap_pkg::target_req_s tgt_req,
  output logic [15:0] tgt_rdata
);
  logic [15:0] noise_reg;
  // An undriven bus must not look like a stale answer, so it flips each cycle.
  always_ff @(posedge clk) begin
    noise_reg <= resetn ? ~noise_reg : 16'h5a0f;
  end
  assign tgt_rdata = (tgt_req.req && !tgt_req.wr) ? tgt_req.addr[15:0] ^ 16'ha5c3 : noise_reg;
endmodule // target_model

// file: test/tb.sv
/*
  Self-checking bench for the memory map and page arbiter.
  Assumes the bound checker and the target model on the far side.
*/
`timescale 1ns/10ps
module tb;
  logic clk, resetn, single_chip, debug_active, debug_page_en, debug_hw_cmd;
  logic cpu_firmware, debug_read_cycle, debug_write_cycle, cpu_op_done;
  logic call_start, call_indirect, rtc_start, cpu_grant, cpu_stall, dbg_grant;
  logic push_ret, push_page, pull_page, pull_ret, refill, cpu_no_irq, illegal_reset, ill;
  logic [7:0] call_imm_page, call_mem_page, stack_pull_data, push_data, seed, pg;
  logic [15:0] cpu_rdata, dbg_rdata, tgt_rdata, a, rd;
  mmap_pkg::master_req_s cpu_req, dbg_req;
  mmap_pkg::target_req_s tgt_req, t;
  mmap_pkg::target_e tgt_sel, sel;
  int fails, total_checks, n;
  logic [18:0] ill_tbl [6] = '{{2'b00, 16'h0480, 1'b1}, {2'b00, 16'h0400, 1'b1},
    {2'b01, 16'h0500, 1'b0}, {2'b10, 16'h0600, 1'b0}, {2'b00, 16'h0800, 1'b0},
    {2'b00, 16'h0100, 1'b0}};
  logic [18:0] dm_tbl [4] = '{{16'hff00, 3'b011}, {16'hff40, 3'b111}, {16'hff80, 3'b000},
    {16'hbf00, 3'b011}};

  memory_map_page_arbiter i_dut (.clk, .resetn, .single_chip, .debug_active, .debug_page_en,
    .debug_hw_cmd, .cpu_firmware, .debug_read_cycle, .debug_write_cycle, .cpu_req,
    .cpu_op_done, .cpu_grant, .cpu_stall, .cpu_rdata, .dbg_req, .dbg_grant, .dbg_rdata,
    .call_start, .call_indirect, .call_imm_page, .call_mem_page, .rtc_start,
    .stack_pull_data, .push_ret, .push_page, .push_data, .pull_page, .pull_ret, .refill,
    .cpu_no_irq, .tgt_req, .tgt_sel, .tgt_rdata, .illegal_reset);
  target_model i_tgt (.clk, .resetn, .tgt_req, .tgt_rdata);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [17:0] paged(input logic [3:0] p, input logic [15:0] la);
    return {p, la[13:0]};
  endfunction
  function automatic logic [15:0] swp(input logic [17:0] g);
    return {g[7:0] ^ 8'hc3, g[15:8] ^ 8'ha5};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic acc(input bit dbg, input logic wr, input logic [15:0] ad, wd);
    mmap_pkg::master_req_s r;
    logic g;
    r = '{1'b1, wr, ~ad[0], ad, wd};
    @(posedge clk);
    if (dbg) dbg_req <= r; else cpu_req <= r;
    // The other master is idle, so the request is taken at once; holding it takes it twice.
    @(posedge clk);
    r = '{1'b0, ~wr, 1'b0, ~ad, ~wd};
    if (dbg) dbg_req <= r; else cpu_req <= r;
    @(posedge clk);
    g = dbg ? dbg_grant : cpu_grant;
    t = tgt_req;
    sel = tgt_sel;
    ill = illegal_reset;
    chk("grant", 1, g);
    @(posedge clk);
    rd = dbg ? dbg_rdata : cpu_rdata;
  endtask
  task automatic wait_seq();
    for (n = 0; n < 20 && refill !== 1'b1; n++) begin
      @(posedge clk);
      if (push_page === 1'b1) chk("saved page", pg, push_data);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    chk("watchdog", 0, 1);
    print_verdict();
  end
  initial begin
    {resetn, single_chip, debug_active, debug_page_en, debug_hw_cmd, cpu_firmware} = '0;
    {debug_read_cycle, debug_write_cycle, cpu_op_done, call_start, call_indirect} = '0;
    {rtc_start, call_imm_page, call_mem_page, stack_pull_data} = '0;
    cpu_req = '0;
    dbg_req = '0;
    fails = 0;
    total_checks = 0;
    seed = 8'h4a;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    acc(0, 0, 16'h8124, 0);
    chk("reset page", paged(4'he, 16'h8124), t.addr);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      pg = seed;
      a = {2'b00, lfsr(seed), seed[5:0]};
      acc(0, 1, 16'h0030, {pg, pg});
      chk("write data", {pg, pg}, t.wdata);
      acc(0, 0, 16'h8000 | a, 0);
      chk("window", paged(pg[3:0], a), t.addr);
      chk("cpu data", swp(paged(pg[3:0], a)), rd);
      acc(0, 0, 16'hc000 | a, 0);
      chk("fixed", paged(4'hf, a), t.addr);
    end
    debug_page_en <= 1'b1;
    debug_hw_cmd <= 1'b1;
    acc(1, 0, 16'h8010, 0);
    chk("debug page", paged(4'hf, 16'h8010), t.addr);
    chk("debug data", 16'hc010 ^ 16'ha5c3, rd);
    debug_hw_cmd <= 1'b0;
    acc(1, 0, 16'h8010, 0);
    chk("program page", paged(pg[3:0], 16'h8010), t.addr);
    for (int k = 0; k < 2; k++) begin
      call_indirect <= k[0];
      call_imm_page <= 8'h3d;
      call_mem_page <= 8'h3c;
      call_start <= 1'b1;
      @(posedge clk);
      call_start <= 1'b0;
      wait_seq();
      pg = k ? 8'h3c : 8'h3d;
      acc(0, 0, 16'h8200, 0);
      chk("call page", paged(pg[3:0], 16'h8200), t.addr);
    end
    stack_pull_data <= 8'h3b;
    rtc_start <= 1'b1;
    @(posedge clk);
    rtc_start <= 1'b0;
    wait_seq();
    acc(0, 0, 16'h8200, 0);
    chk("return page", paged(4'hb, 16'h8200), t.addr);
    single_chip <= 1'b1;
    foreach (ill_tbl[k]) begin
      cpu_firmware <= ill_tbl[k][17];
      acc(ill_tbl[k][18], 0, ill_tbl[k][16:1], 0);
      chk("illegal", ill_tbl[k][0], ill);
    end
    cpu_firmware <= 1'b0;
    acc(0, 1, 16'h0033, 16'h0101);
    acc(0, 0, 16'h0400, 0);
    chk("info sector", 0, ill);
    acc(0, 1, 16'h0030, 16'hffff);
    debug_active <= 1'b1;
    foreach (dm_tbl[k]) begin
      debug_read_cycle <= dm_tbl[k][1] & ~dm_tbl[k][2];
      debug_write_cycle <= dm_tbl[k][1] & dm_tbl[k][2];
      acc(1, dm_tbl[k][2], dm_tbl[k][18:3], 16'h1234);
      chk("debug target", dm_tbl[k][0], sel == mmap_pkg::TGT_DEBUG);
    end
    {debug_active, debug_read_cycle, debug_write_cycle} <= '0;
    cpu_op_done <= 1'b1;
    @(posedge clk);
    cpu_req <= '{1'b1, 1'b0, 1'b1, 16'hc000, 16'h0};
    dbg_req <= '{1'b1, 1'b0, 1'b1, 16'hc100, 16'h0};
    for (n = 0; n < 300 && dbg_grant !== 1'b1; n++) @(posedge clk);
    chk("starve wait", 1, n >= 128 && n <= 134);
    chk("cpu stall", 1, cpu_stall);
    cpu_req <= '0;
    dbg_req <= '0;
    print_verdict();
  end
endmodule // tb
